// [rtl/ocm_defs.svh]
// Behaviour
// - power-off event in active enters power-off
// - power-off wakes on power line, reset, alarm
// - any power-on event goes to active
// - power saving lets active drop to idle
// - periodic paging wake from idle to active
// - usb remote wakeup returns idle to active
// - select 1 wakes periodically, enables uart
// - no flow control: uart rx wakes idle
// - select 3: rts on wakes idle
// - select 3: dtr on wakes idle
// - preset alarm wakes idle to active
// - connection start or radio need enters connected
// - connected accepts host data unless power saving
// - no data and no radio need suspends connected to active
// - radio need in idle: active then connected
// - connection end returns to active
`ifndef OCM_DEFS_SVH
`define OCM_DEFS_SVH

// register byte offsets
`define OCM_OFF_CTRL       8'h00
`define OCM_OFF_STATUS     8'h04
`define OCM_OFF_PAGE       8'h08
`define OCM_OFF_UARTP      8'h0c

// ctrl fields
`define OCM_CTRL_PS_LSB    0
`define OCM_CTRL_HWFC_BIT  4
`define OCM_CTRL_ALARM_BIT 8

// status fields
`define OCM_STAT_MODE_LSB  0
`define OCM_STAT_UART_BIT  4
`define OCM_STAT_CTS_BIT   5
`define OCM_STAT_PAGE_BIT  6
`define OCM_STAT_ALARM_BIT 8
`define OCM_STAT_CAUSE_LSB 12

// power_saving_select values
`define OCM_PS_OFF         2'h0
`define OCM_PS_PERIODIC    2'h1
`define OCM_PS_HANDSHAKE   2'h3

// wake timers
`define OCM_TW             24
`define OCM_PAGE_RST       24'h00ffff
`define OCM_UARTP_RST      24'h003fff

// last wake cause codes
`define OCM_CAUSE_NONE     3'h0
`define OCM_CAUSE_PAGE     3'h1
`define OCM_CAUSE_USB      3'h2
`define OCM_CAUSE_UART     3'h3
`define OCM_CAUSE_HOST     3'h4
`define OCM_CAUSE_ALARM    3'h5
`define OCM_CAUSE_RADIO    3'h6
`define OCM_CAUSE_POWER    3'h7

`endif

// [rtl/ocm_pkg.sv]
`include "ocm_defs.svh"

package ocm_pkg;

    typedef enum logic [1:0] {
        OCM_OFF,
        OCM_IDLE,
        OCM_ACTIVE,
        OCM_CONN
    } ocm_mode_t;

    typedef struct packed {
        logic [`OCM_TW-1:0] cnt;
        logic               tick;
    } ocm_tmr_t;

    typedef struct packed {
        ocm_mode_t          mode;
        logic [1:0]         ps_sel;
        logic               hw_flow;
        logic               alarm_armed;
        logic [`OCM_TW-1:0] page_period;
        logic [`OCM_TW-1:0] uart_period;
        logic               paging_win;
        logic               uart_en;
        logic               cts_on;
        logic               data_accept;
        logic [2:0]         cause;
        logic               dp_write;
        logic               rd_pend;
        logic [7:0]         dp_addr;
        logic [31:0]        hrdata;
    } ocm_state_t;

endpackage

// [rtl/ocm_wake_timer.sv]
`include "ocm_defs.svh"

// periodic wake source: one-cycle tick every period cycles while run
module ocm_wake_timer (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic               run,
    input  wire logic [`OCM_TW-1:0] period,
    output logic                    tick
);
    ocm_pkg::ocm_tmr_t s_ff;
    ocm_pkg::ocm_tmr_t nxt_s;
    logic [`OCM_TW-1:0] last;

    // a zero period behaves as one so the timer never stalls
    always_comb
    begin
        last = (period == '0) ? '0 : period - `OCM_TW'(1);
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (!run)
        begin
            nxt_s.cnt = '0;
        end
        else if (s_ff.cnt >= last)
        begin
            nxt_s.cnt = '0;
            nxt_s.tick = 1'b1;
        end
        else
        begin
            nxt_s.cnt = s_ff.cnt + `OCM_TW'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;

endmodule

// [rtl/ocm_operating_mode_ctrl.sv]
`include "ocm_defs.svh"

// operating-mode sequencer of the modem with an ahb-lite register slave
module ocm_operating_mode_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // power and wake sources
    input  wire logic        power_on_line,
    input  wire logic        ext_wake_rst_n,
    input  wire logic        rtc_alarm,
    input  wire logic        power_off_event,
    input  wire logic        idle_allowed,
    input  wire logic        usb_remote_wakeup,
    // uart handshake from the host
    input  wire logic        uart_rxd,
    input  wire logic        uart_rts_on,
    input  wire logic        uart_dtr_on,
    // radio connection status
    input  wire logic        radio_conn_start,
    input  wire logic        radio_rf_needed,
    input  wire logic        radio_data_busy,
    input  wire logic        radio_conn_end,
    // mode outputs
    output logic [1:0]       op_mode,
    output logic             uart_enabled,
    output logic             uart_cts_on,
    output logic             host_data_accept,
    output logic             paging_window
);
    ocm_pkg::ocm_state_t s_ff;
    ocm_pkg::ocm_state_t nxt_s;

    logic page_tick;
    logic uart_tick;
    logic in_idle;

    assign in_idle = (s_ff.mode == ocm_pkg::OCM_IDLE);

    // paging interval runs only while idle; the interval itself is
    // network-driven, software reprograms it as conditions change
    // limitation: a new period acts on the running count, not after it
    ocm_wake_timer u_page_tmr (
        .sys_clk (sys_clk),
        .srst    (srst),
        .run     (in_idle),
        .period  (s_ff.page_period),
        .tick    (page_tick)
    );

    // periodic uart window, only meaningful with select 1
    // the count restarts on every idle entry, so a short visit never ticks
    ocm_wake_timer u_uart_tmr (
        .sys_clk (sys_clk),
        .srst    (srst),
        .run     (in_idle && (s_ff.ps_sel == `OCM_PS_PERIODIC)),
        .period  (s_ff.uart_period),
        .tick    (uart_tick)
    );

    // decoded conditions
    logic       ps_en;
    logic       hs_mode;
    logic       on_event;
    logic       alarm_hit;
    logic       w_page;
    logic       w_usb;
    logic       w_uart;
    logic       w_rx;
    logic       w_host;
    logic       w_radio;
    logic       host_hold;
    logic       addr_take;
    logic [7:0] waddr;
    logic [31:0] rd_mux;

    always_comb
    begin
        ps_en     = (s_ff.ps_sel != `OCM_PS_OFF);
        hs_mode   = (s_ff.ps_sel == `OCM_PS_HANDSHAKE);
        alarm_hit = rtc_alarm && s_ff.alarm_armed;
        // power line high or reset line low switches the device on
        on_event  = power_on_line || !ext_wake_rst_n || alarm_hit;
        w_page    = page_tick;
        w_usb     = usb_remote_wakeup;
        w_uart    = uart_tick;
        // start bit on rx; only a wake source without flow control
        w_rx      = !uart_rxd && !s_ff.hw_flow && ps_en;
        w_host    = hs_mode && (uart_rts_on || uart_dtr_on);
        w_radio   = radio_rf_needed || radio_conn_start;
        // with select 3, a host still holding rts or dtr on keeps the device awake
        host_hold = hs_mode && (uart_rts_on || uart_dtr_on);
    end

    // register read mux, unmapped offsets read as zero
    always_comb
    begin
        rd_mux = '0;
        case (s_ff.dp_addr)
            `OCM_OFF_CTRL:
            begin
                rd_mux[`OCM_CTRL_PS_LSB +: 2]  = s_ff.ps_sel;
                rd_mux[`OCM_CTRL_HWFC_BIT]     = s_ff.hw_flow;
                rd_mux[`OCM_CTRL_ALARM_BIT]    = s_ff.alarm_armed;
            end
            `OCM_OFF_STATUS:
            begin
                rd_mux[`OCM_STAT_MODE_LSB +: 2]  = 2'(s_ff.mode);
                rd_mux[`OCM_STAT_UART_BIT]       = s_ff.uart_en;
                rd_mux[`OCM_STAT_CTS_BIT]        = s_ff.cts_on;
                rd_mux[`OCM_STAT_PAGE_BIT]       = s_ff.paging_win;
                rd_mux[`OCM_STAT_ALARM_BIT]      = s_ff.alarm_armed;
                rd_mux[`OCM_STAT_CAUSE_LSB +: 3] = s_ff.cause;
            end
            `OCM_OFF_PAGE:
            begin
                rd_mux[`OCM_TW-1:0] = s_ff.page_period;
            end
            `OCM_OFF_UARTP:
            begin
                rd_mux[`OCM_TW-1:0] = s_ff.uart_period;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    // next-state: bus slave, register writes, mode machine
    always_comb
    begin
        nxt_s = s_ff;
        waddr = s_ff.dp_addr;
        addr_take = hsel && hready && htrans[1];

        // bus address phase; only word transfers are expected
        // hsize is not decoded, so a narrow access acts on the whole word
        // the address is registered because the data follow one cycle later
        nxt_s.dp_write = addr_take && hwrite;
        nxt_s.rd_pend  = addr_take && !hwrite;
        if (addr_take)
        begin
            nxt_s.dp_addr = {haddr[7:2], 2'b00};
        end

        // read data phase: one wait cycle loads the output flop
        // the wait state keeps hrdata a plain flop output at the cost of speed
        if (s_ff.rd_pend)
        begin
            nxt_s.hrdata = rd_mux;
        end

        // a preset alarm is consumed when it fires
        // so a level alarm line cannot wake the device a second time
        if (alarm_hit && (s_ff.mode == ocm_pkg::OCM_OFF ||
                          s_ff.mode == ocm_pkg::OCM_IDLE))
        begin
            nxt_s.alarm_armed = 1'b0;
        end

        // write data phase; a software arm wins over the consume above
        if (s_ff.dp_write)
        begin
            case (waddr)
                `OCM_OFF_CTRL:
                begin
                    nxt_s.ps_sel  = hwdata[`OCM_CTRL_PS_LSB +: 2];
                    nxt_s.hw_flow = hwdata[`OCM_CTRL_HWFC_BIT];
                    if (hwdata[`OCM_CTRL_ALARM_BIT])
                    begin
                        nxt_s.alarm_armed = 1'b1;
                    end
                end
                `OCM_OFF_PAGE:
                begin
                    nxt_s.page_period = hwdata[`OCM_TW-1:0];
                end
                `OCM_OFF_UARTP:
                begin
                    nxt_s.uart_period = hwdata[`OCM_TW-1:0];
                end
                default:
                begin
                    // status and unmapped offsets ignore writes
                    nxt_s.page_period = s_ff.page_period;
                end
            endcase
        end

        // operating-mode machine
        case (s_ff.mode)
            ocm_pkg::OCM_OFF:
            begin
                if (on_event)
                begin
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = alarm_hit ? `OCM_CAUSE_ALARM
                                            : `OCM_CAUSE_POWER;
                end
            end
            ocm_pkg::OCM_IDLE:
            begin
                // sources that fire together record only the top-ranked cause
                // radio need wakes to active; connected follows next
                if (w_radio)
                begin
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = `OCM_CAUSE_RADIO;
                end
                else if (alarm_hit)
                begin
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = `OCM_CAUSE_ALARM;
                end
                else if (w_usb)
                begin
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = `OCM_CAUSE_USB;
                end
                else if (w_host)
                begin
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = `OCM_CAUSE_HOST;
                end
                else if (w_uart || w_rx)
                begin
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = `OCM_CAUSE_UART;
                end
                else if (w_page)
                begin
                    nxt_s.mode       = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause      = `OCM_CAUSE_PAGE;
                    nxt_s.paging_win = 1'b1;
                end
                else if (!ps_en)
                begin
                    // power saving turned off while asleep
                    nxt_s.mode  = ocm_pkg::OCM_ACTIVE;
                    nxt_s.cause = `OCM_CAUSE_NONE;
                end
            end
            ocm_pkg::OCM_ACTIVE:
            begin
                // power-off outranks everything else in active
                // a host holding rts or dtr on blocks idle so its wake cannot bounce
                if (power_off_event)
                begin
                    nxt_s.mode       = ocm_pkg::OCM_OFF;
                    nxt_s.paging_win = 1'b0;
                end
                else if (w_radio)
                begin
                    nxt_s.mode       = ocm_pkg::OCM_CONN;
                    nxt_s.paging_win = 1'b0;
                end
                else if (ps_en && idle_allowed && !host_hold)
                begin
                    nxt_s.mode       = ocm_pkg::OCM_IDLE;
                    nxt_s.paging_win = 1'b0;
                end
            end
            ocm_pkg::OCM_CONN:
            begin
                // a pending rf need alone keeps the link up without busy data
                if (radio_conn_end)
                begin
                    nxt_s.mode = ocm_pkg::OCM_ACTIVE;
                end
                else if (!radio_data_busy && !radio_rf_needed)
                begin
                    nxt_s.mode = ocm_pkg::OCM_ACTIVE;
                end
            end
            default:
            begin
                // an illegal mode code falls back to active, the safe awake state
                nxt_s.mode = ocm_pkg::OCM_ACTIVE;
            end
        endcase

        // uart is live whenever the core is awake
        // trade-off: with select 1 and idle allowed the window is one active
        // cycle; a host wanting longer must hold the device awake
        nxt_s.uart_en = (nxt_s.mode == ocm_pkg::OCM_ACTIVE) ||
                        (nxt_s.mode == ocm_pkg::OCM_CONN);
        // with flow control and select 1 or 3 cts tracks the uart;
        // otherwise cts stays on so the host is never blocked
        if (nxt_s.hw_flow && (nxt_s.ps_sel == `OCM_PS_PERIODIC ||
                              nxt_s.ps_sel == `OCM_PS_HANDSHAKE))
        begin
            nxt_s.cts_on = nxt_s.uart_en;
        end
        else
        begin
            nxt_s.cts_on = 1'b1;
        end
        nxt_s.data_accept = (nxt_s.mode == ocm_pkg::OCM_CONN) &&
                            (nxt_s.ps_sel == `OCM_PS_OFF);
    end

    // reset models a fresh power-on: active, saving disabled
    // the timers share this reset so no stale tick survives it
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_ff             <= '0;
            s_ff.mode        <= ocm_pkg::OCM_ACTIVE;
            s_ff.ps_sel      <= `OCM_PS_OFF;
            s_ff.page_period <= `OCM_PAGE_RST;
            s_ff.uart_period <= `OCM_UARTP_RST;
            s_ff.uart_en     <= 1'b1;
            s_ff.cts_on      <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ports; every mode output is a flop, so all of them move on one edge
    // hresp is fixed at okay: unmapped offsets answer too, as zero
    assign hreadyout        = !s_ff.rd_pend;
    assign hresp            = 1'b0;
    assign hrdata           = s_ff.hrdata;
    assign op_mode          = 2'(s_ff.mode);
    assign uart_enabled     = s_ff.uart_en;
    assign uart_cts_on      = s_ff.cts_on;
    assign host_data_accept = s_ff.data_accept;
    assign paging_window    = s_ff.paging_win;

endmodule

// [verif/ocm_omc_sva.sv]
module ocm_omc_sva (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic [1:0] op_mode,
    input wire logic       power_off_event,
    input wire logic       power_on_line,
    input wire logic       ext_wake_rst_n,
    input wire logic       radio_conn_start,
    input wire logic       radio_conn_end,
    input wire logic       radio_data_busy,
    input wire logic       radio_rf_needed,
    input wire logic       usb_remote_wakeup,
    input wire logic       uart_enabled,
    input wire logic       uart_cts_on,
    input wire logic       host_data_accept,
    input wire logic       hreadyout,
    input wire logic       hresp
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // mode moves land one edge after their cause
    property p_off; op_mode == 2'h2 && power_off_event |=> op_mode == 2'h0; endproperty
    a_off: assert property (p_off) else $error("active did not power off");
    property p_on; op_mode == 2'h0 && (power_on_line || !ext_wake_rst_n) |=> op_mode == 2'h2;
    endproperty
    a_on: assert property (p_on) else $error("power-off did not switch on");
    property p_offx; op_mode == 2'h0 |=> op_mode == 2'h0 || op_mode == 2'h2; endproperty
    a_offx: assert property (p_offx) else $error("power-off left to a wrong mode");
    property p_conn; op_mode == 2'h2 && radio_conn_start && !power_off_event |=> op_mode == 2'h3;
    endproperty
    a_conn: assert property (p_conn) else $error("connection start ignored");
    property p_susp; op_mode == 2'h3 && !radio_data_busy && !radio_rf_needed |=> op_mode == 2'h2;
    endproperty
    a_susp: assert property (p_susp) else $error("connected not suspended");
    property p_end; op_mode == 2'h3 && radio_conn_end |=> op_mode == 2'h2; endproperty
    a_end: assert property (p_end) else $error("connection end ignored");
    property p_usb; op_mode == 2'h1 && usb_remote_wakeup |=> op_mode == 2'h2; endproperty
    a_usb: assert property (p_usb) else $error("usb wakeup ignored");
    // uart state is a pure function of the mode, so the two never drift
    property p_uart; uart_enabled == op_mode[1]; endproperty
    a_uart: assert property (p_uart) else $error("uart enable disagrees with mode");
    property p_acc; host_data_accept |-> op_mode == 2'h3; endproperty
    a_acc: assert property (p_acc) else $error("host data accepted outside connected");
    property p_cts; !uart_cts_on |-> !uart_enabled; endproperty
    a_cts: assert property (p_cts) else $error("cts off while uart enabled");
    property p_rdy; !hreadyout |=> hreadyout && !hresp; endproperty
    a_rdy: assert property (p_rdy) else $error("bus wait longer than one cycle");
endmodule

// [verif/ocm_host_dte.sv]
// host side: one wake line per request code, registered like a real uart driver
module ocm_host_dte (
    input  wire logic       sys_clk,
    input  wire logic [2:0] req,
    output logic            uart_rxd,
    output logic            uart_rts_on,
    output logic            uart_dtr_on,
    output logic            usb_remote_wakeup
);
    timeunit 1ns;
    timeprecision 100ps;
    initial uart_rxd = 1'b1;
    initial {uart_rts_on, uart_dtr_on, usb_remote_wakeup} = 3'h0;
    // rxd idles high and falls for a start bit when data is sent
    always @(posedge sys_clk)
    begin
        uart_rxd          <= (req != 3'h1);
        uart_rts_on       <= (req == 3'h2);
        uart_dtr_on       <= (req == 3'h3);
        usb_remote_wakeup <= (req == 3'h4);
    end
endmodule

// [verif/test_operating_mode_controller.sv]
module test_operating_mode_controller;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0, op_mode;
    logic        hready, hreadyout, hresp, uart_rxd, uart_rts_on, uart_dtr_on;
    logic        power_on_line = 1'b0, ext_wake_rst_n = 1'b1, rtc_alarm = 1'b0;
    logic        power_off_event = 1'b0, idle_allowed = 1'b0, radio_conn_start = 1'b0;
    logic        radio_rf_needed = 1'b0, radio_data_busy = 1'b0, radio_conn_end = 1'b0;
    logic        usb_remote_wakeup, uart_enabled, uart_cts_on, host_data_accept, paging_window;
    logic [2:0]  req = 3'h0;
    logic [2:0]  reqs [4] = '{3'h4, 3'h2, 3'h3, 3'h1};
    logic [2:0]  causes [7] = '{3'h2, 3'h4, 3'h4, 3'h3, 3'h5, 3'h6, 3'h1};
    int          err_count = 0, total_checks = 0, k;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    ocm_operating_mode_ctrl dut_u (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .power_on_line,
        .ext_wake_rst_n, .rtc_alarm, .power_off_event, .idle_allowed, .usb_remote_wakeup,
        .uart_rxd, .uart_rts_on, .uart_dtr_on, .radio_conn_start, .radio_rf_needed,
        .radio_data_busy, .radio_conn_end, .op_mode, .uart_enabled, .uart_cts_on,
        .host_data_accept, .paging_window);
    ocm_host_dte dte_u (.sys_clk, .req, .uart_rxd, .uart_rts_on, .uart_dtr_on,
        .usb_remote_wakeup);
    initial forever #12.5 sys_clk = ~sys_clk;
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ready is judged on the settled value that the next rising edge samples
    task rdy();
        logic r;
        do
        begin
            @(negedge sys_clk);
            r = hreadyout;
            rd = hrdata;
            @(posedge sys_clk);
        end while (r !== 1'b1);
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
    endtask
    task wait_mode(input logic [1:0] m);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (op_mode !== m && i < 60)
        begin
            @(negedge sys_clk);
            i++;
        end
        chk("op_mode", {30'h0, op_mode}, {30'h0, m});
        @(posedge sys_clk);
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 32'h4, 32'h0);
        chk("status", rd, 32'h32);
        bus(1'b0, 32'h0, 32'h0);
        chk("ctrl", rd, 32'h0);
        bus(1'b1, 32'h10, 32'h5);
        bus(1'b0, 32'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        // power cycle through each switch-on source; alarm must be armed
        bus(1'b1, 32'h0, 32'h100);
        for (k = 0; k < 3; k++)
        begin
            power_off_event <= 1'b1;
            wait_mode(2'h0);
            power_off_event <= 1'b0;
            power_on_line <= (k == 0);
            ext_wake_rst_n <= (k != 1);
            rtc_alarm <= (k == 2);
            wait_mode(2'h2);
            power_on_line <= 1'b0;
            ext_wake_rst_n <= 1'b1;
            rtc_alarm <= 1'b0;
        end
        bus(1'b0, 32'h0, 32'h0);
        chk("alarm armed", rd, 32'h0);
        $display("test power done");
        radio_conn_start <= 1'b1;
        radio_data_busy <= 1'b1;
        wait_mode(2'h3);
        radio_conn_start <= 1'b0;
        @(negedge sys_clk);
        chk("accept", {31'h0, host_data_accept}, 32'h1);
        @(posedge sys_clk);
        bus(1'b1, 32'h0, 32'h1);
        @(negedge sys_clk);
        chk("accept", {31'h0, host_data_accept}, 32'h0);
        @(posedge sys_clk);
        radio_conn_end <= 1'b1;
        wait_mode(2'h2);
        radio_conn_end <= 1'b0;
        radio_rf_needed <= 1'b1;
        wait_mode(2'h3);
        radio_rf_needed <= 1'b0;
        radio_data_busy <= 1'b0;
        wait_mode(2'h2);
        idle_allowed <= 1'b1;
        wait_mode(2'h1);
        @(negedge sys_clk);
        chk("uart_enabled", {31'h0, uart_enabled}, 32'h0);
        @(posedge sys_clk);
        bus(1'b1, 32'h0, 32'h11);
        @(negedge sys_clk);
        chk("cts", {31'h0, uart_cts_on}, 32'h0);
        @(posedge sys_clk);
        bus(1'b1, 32'hc, 32'h8);
        wait_mode(2'h2);
        bus(1'b0, 32'h4, 32'h0);
        chk("cause", {29'h0, rd[14:12]}, 32'h3);
        $display("test connected done");
        // handshake saving: every idle wake source, paging last as it keeps firing
        bus(1'b1, 32'h0, 32'h3);
        bus(1'b1, 32'hc, 32'h3fff);
        for (k = 0; k < 7; k++)
        begin
            if (k == 4)
                bus(1'b1, 32'h0, 32'h103);
            if (k == 6)
                bus(1'b1, 32'h8, 32'h8);
            wait_mode(2'h1);
            req <= (k < 4) ? reqs[k] : 3'h0;
            idle_allowed <= (k != 6);
            rtc_alarm <= (k == 4);
            radio_conn_start <= (k == 5);
            wait_mode(2'h2);
            req <= 3'h0;
            rtc_alarm <= 1'b0;
            if (k == 5)
                wait_mode(2'h3);
            radio_conn_start <= 1'b0;
            // idle is withheld on the paging wake so the window can be seen
            if (k == 6)
            begin
                @(negedge sys_clk);
                chk("paging_window", {31'h0, paging_window}, 32'h1);
                @(posedge sys_clk);
            end
            bus(1'b0, 32'h4, 32'h0);
            chk("cause", {29'h0, rd[14:12]}, {29'h0, causes[k]});
        end
        $display("test wake done");
        // select 2 saves power with no periodic uart or handshake wake; clearing it wakes the device
        bus(1'b1, 32'h8, 32'hffff);
        bus(1'b1, 32'h0, 32'h2);
        idle_allowed <= 1'b1;
        wait_mode(2'h1);
        bus(1'b1, 32'h0, 32'h0);
        wait_mode(2'h2);
        bus(1'b0, 32'h4, 32'h0);
        chk("status", rd, 32'h32);
        $display("test saving done");
        conclude();
    end
endmodule
bind ocm_operating_mode_ctrl ocm_omc_sva chk_u (.sys_clk, .srst, .op_mode, .power_off_event,
    .power_on_line, .ext_wake_rst_n, .radio_conn_start, .radio_conn_end, .radio_data_busy,
    .radio_rf_needed, .usb_remote_wakeup, .uart_enabled, .uart_cts_on, .host_data_accept,
    .hreadyout, .hresp);
